// ===== reset_state_initializer.sv
// Reset cause flags and forced initial core state
`timescale 1ns/100ps
`include "rsi_consts.svh"
// Overview of operation
// - Power-on clears both flags; watchdog time-out while halted sets both.
// - Watchdog time-out when running sets timeout flag, keeps power-down flag.
// - Low-voltage reset while running leaves both flags unchanged.
// - Flags live in status; halting and the watchdog update them.
// - After power-on every interrupt source is disabled until software enables it.
// - After any reset the watchdog count clears and counting restarts at once.
// - After power-on all timer modules are switched off.
// - After power-on all pins are inputs, analog channel pins set to converter.
// - After power-on the stack pointer points to the stack top.
module reset_state_initializer (
  // Clock and reset
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_arst_n,
  // Reset cause and mode
  input  wire rsi_pkg::reset_req_s  i_req,
  input  wire rsi_pkg::op_mode_e    i_mode,
  // Software status updates
  input  wire logic                 i_halt_enter,
  input  wire logic                 i_wdt_clear,
  input  wire logic                 i_sw_wr,
  input  wire rsi_pkg::core_state_s i_sw_state,
  // Outputs
  output logic                      o_timeout_flag,
  output logic                      o_power_down_flag,
  output rsi_pkg::core_state_s      o_state,
  output rsi_pkg::wdt_count_t       o_watchdog_timer,
  output logic                      o_core_reset
);
  import rsi_pkg::*;

  logic        rst_sync1;
  logic        rst_n;
  logic        timeout_flag;
  logic        power_down_flag;
  logic        next_timeout_flag;
  logic        next_power_down_flag;
  core_state_s state;
  core_state_s next_state;
  wdt_count_t  wdt;
  wdt_count_t  next_wdt;
  logic        halted;
  logic        any_req;
  logic        core_reset;
  logic        next_core_reset;

  // Reset release through two flops; the first feeds only the second
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_sync1 <= 1'b0;
      rst_n     <= 1'b0;
    end else begin
      rst_sync1 <= 1'b1;
      rst_n     <= rst_sync1;
    end
  end

  assign halted  = (i_mode == MODE_IDLE) || (i_mode == MODE_SLEEP);
  assign any_req = i_req.por | i_req.low_voltage_reset | i_req.wdt;

  // Full power-on image of the core
  function automatic core_state_s por_image();
    core_state_s s;
    s.pc                  = `RSI_PC_RESET;
    s.pc_low_byte         = `RSI_PCL_RESET;
    s.sp                  = `RSI_SP_TOP;
    s.int_en              = `RSI_INT_RESET;
    s.tmr_on              = `RSI_TMR_OFF;
    s.io_dir_in           = `RSI_IO_INPUT;
    s.analog_channel_pins = `RSI_AN_ALL;
    return s;
  endfunction

  // Flag update; power-on has priority over watchdog over low-voltage
  always_comb begin
    next_timeout_flag    = timeout_flag;
    next_power_down_flag = power_down_flag;
    if (i_req.por) begin
      next_timeout_flag    = 1'b0;
      next_power_down_flag = 1'b0;
    end else if (i_req.wdt) begin
      next_timeout_flag = 1'b1;
      if (halted) begin
        next_power_down_flag = 1'b1;
      end
    end else if (i_req.low_voltage_reset) begin
      next_timeout_flag    = timeout_flag;
      next_power_down_flag = power_down_flag;
    end else begin
      // Halt entry sets power-down and clears timeout; a watchdog clear clears both
      if (i_halt_enter) begin
        next_power_down_flag = 1'b1;
        next_timeout_flag    = 1'b0;
      end else if (i_wdt_clear) begin
        next_power_down_flag = 1'b0;
        next_timeout_flag    = 1'b0;
      end
    end
  end

  // Core state; a halted watchdog reset only touches PC and SP
  always_comb begin
    next_state = state;
    if (i_req.por || i_req.low_voltage_reset || (i_req.wdt && !halted)) begin
      next_state = por_image();
    end else if (i_req.wdt) begin
      next_state.pc          = `RSI_PC_RESET;
      next_state.pc_low_byte = `RSI_PCL_RESET;
      next_state.sp          = `RSI_SP_TOP;
    end else if (i_sw_wr) begin
      next_state = i_sw_state;
    end
    if (any_req) begin
      next_state.pc          = `RSI_PC_RESET;
      next_state.pc_low_byte = `RSI_PCL_RESET;
    end
  end

  // Watchdog clears on any reset and then counts with no software help
  always_comb begin
    next_wdt        = wdt + `RSI_WDT_ONE;
    next_core_reset = any_req;
    if (any_req || i_wdt_clear) begin
      next_wdt = `RSI_WDT_CLEAR;
    end
  end

  // Registers; a power-on image is also loaded by the asynchronous reset
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      timeout_flag    <= 1'b0;
      power_down_flag <= 1'b0;
      state           <= '{pc: `RSI_PC_RESET, pc_low_byte: `RSI_PCL_RESET,
                           sp: `RSI_SP_TOP, int_en: `RSI_INT_RESET,
                           tmr_on: `RSI_TMR_OFF, io_dir_in: `RSI_IO_INPUT,
                           analog_channel_pins: `RSI_AN_ALL};
      wdt             <= `RSI_WDT_CLEAR;
      core_reset      <= 1'b1;
    end else begin
      timeout_flag    <= next_timeout_flag;
      power_down_flag <= next_power_down_flag;
      state           <= next_state;
      wdt             <= next_wdt;
      core_reset      <= next_core_reset;
    end
  end

  assign o_timeout_flag    = timeout_flag;
  assign o_power_down_flag = power_down_flag;
  assign o_state           = state;
  assign o_watchdog_timer  = wdt;
  assign o_core_reset      = core_reset;

  property p_por_flags;
    @(posedge i_ref_clk) disable iff (!rst_n)
    i_req.por |=> !timeout_flag && !power_down_flag;
  endproperty
  a_por_flags: assert property (p_por_flags) else $error("por flags");

  property p_halt_wdt;
    @(posedge i_ref_clk) disable iff (!rst_n)
    (i_req.wdt && !i_req.por && halted) |=> timeout_flag && power_down_flag;
  endproperty
  a_halt_wdt: assert property (p_halt_wdt) else $error("halt wdt flags");

  property p_run_wdt;
    @(posedge i_ref_clk) disable iff (!rst_n)
    (i_req.wdt && !i_req.por && !halted) |=> timeout_flag && $stable(power_down_flag);
  endproperty
  a_run_wdt: assert property (p_run_wdt) else $error("run wdt flags");

  property p_lvr;
    @(posedge i_ref_clk) disable iff (!rst_n)
    (i_req.low_voltage_reset && !i_req.por && !i_req.wdt) |=> $stable(timeout_flag) && $stable(power_down_flag);
  endproperty
  a_lvr: assert property (p_lvr) else $error("lvr flags");

  property p_int_off;
    @(posedge i_ref_clk) disable iff (!rst_n)
    i_req.por |=> state.int_en == `RSI_INT_RESET && state.tmr_on == `RSI_TMR_OFF;
  endproperty
  a_int_off: assert property (p_int_off) else $error("int or timer on");

  property p_wdt_run;
    @(posedge i_ref_clk) disable iff (!rst_n)
    (any_req ##1 !any_req && !i_wdt_clear) |=> wdt == `RSI_WDT_ONE;
  endproperty
  a_wdt_run: assert property (p_wdt_run) else $error("wdt not counting");

  property p_io_sp;
    @(posedge i_ref_clk) disable iff (!rst_n)
    i_req.por |=> state.io_dir_in == `RSI_IO_INPUT && state.sp == `RSI_SP_TOP
      && state.analog_channel_pins == `RSI_AN_ALL;
  endproperty
  a_io_sp: assert property (p_io_sp) else $error("io or sp wrong");

  property p_pc;
    @(posedge i_ref_clk) disable iff (!rst_n)
    any_req |=> state.pc == `RSI_PC_RESET && state.pc_low_byte == `RSI_PCL_RESET;
  endproperty
  a_pc: assert property (p_pc) else $error("pc not cleared");

  property p_keep;
    @(posedge i_ref_clk) disable iff (!rst_n)
    (i_req.wdt && halted && !i_req.por && !i_req.low_voltage_reset) |=> $stable(state.int_en)
      && $stable(state.tmr_on) && $stable(state.io_dir_in);
  endproperty
  a_keep: assert property (p_keep) else $error("halt wdt changed ctrl");

  // A halted watchdog reset still returns the stack pointer to the top
  property p_halt_sp;
    @(posedge i_ref_clk) disable iff (!rst_n)
    (i_req.wdt && halted && !i_req.por && !i_req.low_voltage_reset) |=> state.sp == `RSI_SP_TOP;
  endproperty
  a_halt_sp: assert property (p_halt_sp) else $error("halt wdt sp not top");

  // Every request restarts the core in the following cycle
  property p_core_reset;
    @(posedge i_ref_clk) disable iff (!rst_n)
    any_req |=> core_reset;
  endproperty
  a_core_reset: assert property (p_core_reset) else $error("core reset missing");
endmodule

// ===== rsi_consts.svh
// Constants for the reset state initializer
`ifndef RSI_CONSTS_SVH
`define RSI_CONSTS_SVH
`define RSI_PC_W        13
`define RSI_PC_RESET    13'h0000
`define RSI_PCL_RESET   8'h00
`define RSI_SP_W        4
`define RSI_SP_TOP      4'hF
`define RSI_INT_W       32
`define RSI_INT_RESET   32'h0000_0000
`define RSI_TMR_W       4
`define RSI_TMR_OFF     4'h0
`define RSI_IO_W        32
`define RSI_IO_INPUT    32'hFFFF_FFFF
`define RSI_AN_W        8
`define RSI_AN_ALL      8'hFF
`define RSI_WDT_W       16
`define RSI_WDT_CLEAR   16'h0000
`define RSI_WDT_ONE     16'h0001
`endif

// ===== rsi_pkg.sv
// Types for the reset state initializer
`include "rsi_consts.svh"
package rsi_pkg;
  // One-hot reset cause requests, sampled on a clock edge
  typedef struct packed {
    logic por;
    logic low_voltage_reset;
    logic wdt;
  } reset_req_s;
  // Forced core state
  typedef struct packed {
    logic [`RSI_PC_W-1:0]  pc;
    logic [7:0]            pc_low_byte;
    logic [`RSI_SP_W-1:0]  sp;
    logic [`RSI_INT_W-1:0] int_en;
    logic [`RSI_TMR_W-1:0] tmr_on;
    logic [`RSI_IO_W-1:0]  io_dir_in;
    logic [`RSI_AN_W-1:0]  analog_channel_pins;
  } core_state_s;
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_SLOW,
    MODE_IDLE,
    MODE_SLEEP
  } op_mode_e;
  typedef logic [`RSI_WDT_W-1:0] wdt_count_t;
endpackage

// ===== reset_state_initializer_test.sv
// Self-checking testbench for the reset state initializer
`timescale 1ns/100ps
`include "rsi_consts.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module reset_state_initializer_test;
  import rsi_pkg::*;
  logic        clk      = 1'b0;
  logic        arst_n   = 1'b0;
  reset_req_s  req      = '0;
  op_mode_e    mode     = MODE_NORMAL;
  logic        halt     = 1'b0;
  logic        clr      = 1'b0;
  logic        wr       = 1'b0;
  core_state_s sw       = '0;
  logic        to_f;
  logic        pd_f;
  core_state_s st;
  wdt_count_t  wdt;
  logic        core_rst;
  int          mismatches = 0;
  int          checked    = 0;
  core_state_s por_img;
  core_state_s usr_img;
  core_state_s exp_img;

  reset_state_initializer reset_state_initializer_i (
    .i_ref_clk         (clk),
    .i_arst_n          (arst_n),
    .i_req             (req),
    .i_mode            (mode),
    .i_halt_enter      (halt),
    .i_wdt_clear       (clr),
    .i_sw_wr           (wr),
    .i_sw_state        (sw),
    .o_timeout_flag    (to_f),
    .o_power_down_flag (pd_f),
    .o_state           (st),
    .o_watchdog_timer  (wdt),
    .o_core_reset      (core_rst)
  );

  // 250 MHz clock
  initial begin
    forever #2 clk = ~clk;
  end

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // One cycle of inputs from a falling edge; they stand until the next call,
  // so no input is assigned twice in one time step
  task automatic pulse(input reset_req_s r, input logic h, input logic c, input logic w);
    req  = r;
    halt = h;
    clr  = c;
    wr   = w;
    @(negedge clk);
  endtask

  task automatic chk_flags(input logic t, input logic p);
    `CHK("timeout_flag", t, to_f)
    `CHK("power_down_flag", p, pd_f)
  endtask

  // Reset image, free-running watchdog, power-on request with only the power-down flag set
  task automatic t_power_on();
    wdt_count_t w0;
    chk_flags(1'b0, 1'b0);
    `CHK("core_state", por_img, st)
    w0 = wdt;
    @(negedge clk);
    `CHK("watchdog_timer", w0 + `RSI_WDT_ONE, wdt)
    pulse('0, 1'b1, 1'b0, 1'b0);
    chk_flags(1'b0, 1'b1);
    pulse('{por: 1'b1, low_voltage_reset: 1'b0, wdt: 1'b0}, 1'b0, 1'b0, 1'b0);
    chk_flags(1'b0, 1'b0);
    `CHK("core_reset", 1'b1, core_rst)
    $display("test power_on done");
  endtask

  // Watchdog time-out while halted keeps software state except PC and SP
  task automatic t_halted_wdt(input op_mode_e m);
    mode = MODE_NORMAL;
    sw   = usr_img;
    pulse('0, 1'b0, 1'b0, 1'b1);
    `CHK("core_state", usr_img, st)
    pulse('0, 1'b0, 1'b1, 1'b0);
    chk_flags(1'b0, 1'b0);
    mode = m;
    pulse('{por: 1'b0, low_voltage_reset: 1'b0, wdt: 1'b1}, 1'b0, 1'b0, 1'b0);
    chk_flags(1'b1, 1'b1);
    exp_img = usr_img;
    exp_img.pc = `RSI_PC_RESET;
    exp_img.pc_low_byte = `RSI_PCL_RESET;
    exp_img.sp = `RSI_SP_TOP;
    `CHK("core_state", exp_img, st)
    `CHK("watchdog_timer", `RSI_WDT_CLEAR, wdt)
    pulse('0, 1'b0, 1'b0, 1'b0);
    `CHK("watchdog_timer", `RSI_WDT_ONE, wdt)
    $display("test halted_wdt done");
  endtask

  // Watchdog time-out while running, power-down flag kept either way
  task automatic t_run_wdt(input op_mode_e m, input logic pd);
    mode = MODE_NORMAL;
    pulse('0, 1'b0, 1'b1, 1'b0);
    if (pd) begin
      pulse('0, 1'b1, 1'b0, 1'b0);
    end
    mode = m;
    pulse('{por: 1'b0, low_voltage_reset: 1'b0, wdt: 1'b1}, 1'b0, 1'b0, 1'b0);
    chk_flags(1'b1, pd);
    `CHK("core_state", por_img, st)
    $display("test run_wdt done");
  endtask

  // Low-voltage reset leaves both flags as they were
  task automatic t_lvr(input op_mode_e m);
    mode = MODE_NORMAL;
    pulse('0, 1'b1, 1'b0, 1'b0);
    mode = m;
    pulse('{por: 1'b0, low_voltage_reset: 1'b1, wdt: 1'b0}, 1'b0, 1'b0, 1'b0);
    chk_flags(1'b0, 1'b1);
    pulse('{por: 1'b0, low_voltage_reset: 1'b0, wdt: 1'b1}, 1'b0, 1'b0, 1'b0);
    pulse('{por: 1'b0, low_voltage_reset: 1'b1, wdt: 1'b0}, 1'b0, 1'b0, 1'b0);
    chk_flags(1'b1, 1'b1);
    `CHK("core_state", por_img, st)
    $display("test lvr done");
  endtask

  // Asynchronous reset in mid-run restores the power-on image, then counting resumes
  task automatic t_mid_reset();
    sw = usr_img;
    pulse('0, 1'b1, 1'b0, 1'b1);
    chk_flags(1'b0, 1'b1);
    pulse('0, 1'b0, 1'b0, 1'b0);
    arst_n = 1'b0;
    @(negedge clk);
    chk_flags(1'b0, 1'b0);
    `CHK("core_state", por_img, st)
    `CHK("watchdog_timer", `RSI_WDT_CLEAR, wdt)
    `CHK("core_reset", 1'b1, core_rst)
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    `CHK("core_reset", 1'b0, core_rst)
    `CHK("watchdog_timer", `RSI_WDT_ONE, wdt)
    $display("test mid_reset done");
  endtask

  // Main sequence: reset held five cycles, requests from the third edge on
  initial begin
    por_img = '{pc: `RSI_PC_RESET, pc_low_byte: `RSI_PCL_RESET, sp: `RSI_SP_TOP,
                int_en: `RSI_INT_RESET, tmr_on: `RSI_TMR_OFF, io_dir_in: `RSI_IO_INPUT,
                analog_channel_pins: `RSI_AN_ALL};
    usr_img = '{pc: 13'h0ABC, pc_low_byte: 8'h5A, sp: 4'h3, int_en: 32'hA5A5_0F0F,
                tmr_on: 4'hA, io_dir_in: 32'h1234_5678, analog_channel_pins: 8'h0F};
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    t_power_on();
    t_halted_wdt(MODE_SLEEP);
    t_halted_wdt(MODE_IDLE);
    t_run_wdt(MODE_NORMAL, 1'b0);
    t_run_wdt(MODE_SLOW, 1'b1);
    t_lvr(MODE_NORMAL);
    t_lvr(MODE_SLOW);
    t_mid_reset();
    wrap_up();
  end
endmodule
